// file: sewpa_cfg.svh
// Constants of the serial EEPROM write-protect and acknowledge block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SEWPA_CFG_SVH
`define SEWPA_CFG_SVH

// ----------------------------------------------------------------------
// Select byte fields
// ----------------------------------------------------------------------
`define SEWPA_TYPE_MEM 4'ha
`define SEWPA_TYPE_PROT 4'h6
`define SEWPA_CHIP_SET 3'h1
`define SEWPA_CHIP_CLR 3'h3
`define SEWPA_TYPE_MSB 7
`define SEWPA_TYPE_LSB 4
`define SEWPA_CHIP_MSB 3
`define SEWPA_CHIP_LSB 1
`define SEWPA_RW_BIT 0

// ----------------------------------------------------------------------
// Array layout and reset values
// ----------------------------------------------------------------------
`define SEWPA_ADDR_W 8
`define SEWPA_LANE_W 4
`define SEWPA_LOWER_BIT 7
`define SEWPA_ERASED 8'hff
`define SEWPA_ACK_SLOT 4'h8
`define SEWPA_LANE_END 5'h10
`define SEWPA_SDA_IDLE 1'b1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SEWPA_CLK_PERIOD_NS 20
`define SEWPA_T_WRITE_NS 10000000

`endif

// file: sewpa_pkg.sv
// Types shared by the write-protect block and its storage.
// Assumes sewpa_cfg.svh is on the include path.
`include "sewpa_cfg.svh"

package sewpa_pkg;

    // ------------------------------------------------------------------
    // Link side byte phases
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        sewpa_ls_idle = 3'b000,
        sewpa_ls_sel = 3'b001,
        sewpa_ls_addr = 3'b010,
        sewpa_ls_wdata = 3'b011,
        sewpa_ls_rdata = 3'b100
    } sewpa_link_state_t;

    typedef enum logic [1:0] {
        sewpa_kind_mem = 2'b00,
        sewpa_kind_set = 2'b01,
        sewpa_kind_clr = 2'b10,
        sewpa_kind_lock = 2'b11
    } sewpa_kind_t;

    typedef enum logic [1:0] {
        sewpa_cs_idle = 2'b00,
        sewpa_cs_walk = 2'b01,
        sewpa_cs_wait = 2'b10
    } sewpa_core_state_t;

    // Pending write handed from link to core at stop
    typedef struct packed {
        sewpa_kind_t kind;
        logic [3:0] page;
        logic [15:0] mask;
    } sewpa_cmd_t;

    // Static pins seen by the link logic
    typedef struct packed {
        logic [2:0] straps;
        logic hv;
        logic guard;
    } sewpa_pins_t;

endpackage : sewpa_pkg

// file: sewpa_mem.sv
// Two-clock byte storage with registered read data.
// Assumes writer and reader never touch the same word in the same window.
`timescale 1ns/1ps
`default_nettype none
`include "sewpa_cfg.svh"

module sewpa_mem #(
    parameter int AW = 8
) (
    input wire logic wr_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_clk,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    import sewpa_pkg::*;

    logic [7:0] store [0:(1<<AW)-1];

    // ------------------------------------------------------------------
    // Erased content at power-up
    // ------------------------------------------------------------------
    initial begin
        for (int i = 0; i < (1 << AW); i++) begin
            store[i] = `SEWPA_ERASED;
        end
    end

    always_ff @(posedge wr_clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge rd_clk) begin
        rd_data <= store[rd_addr];
    end

endmodule : sewpa_mem
`default_nettype wire

// file: sewpa_wp_ack.sv
// Presence-detect EEPROM core: two-wire slave, protection and write cycle.
// Assumes scl_link_clk is the bus clock pin and the bus has pull-ups.
`timescale 1ns/1ps
`default_nettype none
`include "sewpa_cfg.svh"

module sewpa_wp_ack #(
    parameter int WRITE_CYCLES = `SEWPA_T_WRITE_NS / `SEWPA_CLK_PERIOD_NS
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic scl_link_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic array_write_guard,
    input wire logic strap_select_bit0,
    input wire logic strap_select_bit1,
    input wire logic strap_select_bit2,
    input wire logic strap_high_voltage_level,
    output logic write_busy,
    output logic protect_set,
    output logic protect_locked
);
    import sewpa_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic rst_l1_reg, rst_l2_reg;
    sewpa_pins_t pins_l1_reg, pins_l2_reg;
    logic [2:0] stat_l1_reg, stat_l2_reg;
    sewpa_link_state_t state_reg;
    sewpa_kind_t kind_reg;
    logic rw_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg, tx_reg, addr_reg;
    logic sda_rise_reg, start_tog_reg, start_seen_reg, stop_seen_reg;
    logic commit_reg;
    sewpa_cmd_t cmd_reg;
    logic ack_ok, frame_new, busy_l, set_l, lock_l, lat_we;
    logic [2:0] dec;
    logic [7:0] arr_q, lat_q;
    logic scl_c1_reg, scl_c2_reg, scl_c3_reg;
    logic sda_c1_reg, sda_c2_reg, sda_c3_reg;
    logic commit_c1_reg, commit_c2_reg, stop_tog_reg, stop_evt;
    sewpa_core_state_t cstate_reg;
    sewpa_cmd_t ccmd_reg;
    logic [4:0] lane_reg;
    logic [23:0] wait_reg;
    logic arr_we;
    // No reset: this state models the nonvolatile protection cells
    logic set_nv_reg = 1'b0;
    logic lock_nv_reg = 1'b0;

    // Decode select byte into {valid, kind}
    function automatic logic [2:0] sewpa_decode(input logic [7:0] b,
                                                input sewpa_pins_t p);
        logic [3:0] ty;
        logic [2:0] chip;
        ty = b[`SEWPA_TYPE_MSB:`SEWPA_TYPE_LSB];
        chip = b[`SEWPA_CHIP_MSB:`SEWPA_CHIP_LSB];
        sewpa_decode = 3'h0;
        if (ty == `SEWPA_TYPE_MEM && chip == p.straps) begin
            sewpa_decode = {1'b1, sewpa_kind_mem};
        end else if (ty == `SEWPA_TYPE_PROT) begin
            if (p.hv && chip == `SEWPA_CHIP_SET) begin
                sewpa_decode = {1'b1, sewpa_kind_set};
            end else if (p.hv && chip == `SEWPA_CHIP_CLR) begin
                sewpa_decode = {1'b1, sewpa_kind_clr};
            end else if (chip == p.straps) begin
                sewpa_decode = {1'b1, sewpa_kind_lock};
            end
        end
    endfunction : sewpa_decode

    // ------------------------------------------------------------------
    // Link domain synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge scl_link_clk) begin
        rst_l1_reg <= sys_rst;
        rst_l2_reg <= rst_l1_reg;
    end

    always_ff @(posedge scl_link_clk) begin
        if (rst_l2_reg) begin
            pins_l1_reg <= '0;
            pins_l2_reg <= '0;
            stat_l1_reg <= 3'h0;
            stat_l2_reg <= 3'h0;
        end else begin
            // only driven high guards; floating pin needs a pull-down
            pins_l1_reg <= {strap_select_bit2, strap_select_bit1, strap_select_bit0,
                            strap_high_voltage_level, array_write_guard};
            pins_l2_reg <= pins_l1_reg;
            stat_l1_reg <= {write_busy, set_nv_reg, lock_nv_reg};
            stat_l2_reg <= stat_l1_reg;
        end
    end

    assign busy_l = stat_l2_reg[2];
    assign set_l = stat_l2_reg[1];
    assign lock_l = stat_l2_reg[0];
    assign dec = sewpa_decode(shift_reg, pins_l2_reg);
    assign frame_new = start_tog_reg != start_seen_reg;

    // ------------------------------------------------------------------
    // Acknowledge decision for the byte just shifted in
    // ------------------------------------------------------------------
    always_comb begin
        ack_ok = 1'b0;
        case (state_reg)
            sewpa_ls_sel: begin
                if (dec[2] && !busy_l) begin
                    if (dec[1:0] == sewpa_kind_mem) begin
                        ack_ok = 1'b1;
                    end else if (lock_l) begin
                        ack_ok = 1'b0;
                    end else if (set_l && dec[1:0] == sewpa_kind_set) begin
                        ack_ok = 1'b0;
                    end else begin
                        ack_ok = 1'b1;
                    end
                end
            end
            sewpa_ls_addr: ack_ok = 1'b1;
            sewpa_ls_wdata: begin
                if (kind_reg == sewpa_kind_mem) begin
                    ack_ok = !pins_l2_reg.guard &&
                             !((set_l || lock_l) && !addr_reg[`SEWPA_LOWER_BIT]);
                end else begin
                    ack_ok = !pins_l2_reg.guard &&
                             (kind_reg == sewpa_kind_lock || pins_l2_reg.hv);
                end
            end
            default: ack_ok = 1'b0;
        endcase
    end

    assign lat_we = state_reg == sewpa_ls_wdata && cnt_reg == `SEWPA_ACK_SLOT && ack_ok &&
                    kind_reg == sewpa_kind_mem && !frame_new;

    // ------------------------------------------------------------------
    // Bit engine on rising clock
    // ------------------------------------------------------------------
    always_ff @(posedge scl_link_clk) begin
        if (rst_l2_reg) begin
            state_reg <= sewpa_ls_idle;
            kind_reg <= sewpa_kind_mem;
            rw_reg <= 1'b0;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= `SEWPA_ERASED;
            addr_reg <= 8'h00;
            start_seen_reg <= 1'b0;
            commit_reg <= 1'b0;
            cmd_reg <= '0;
            sda_rise_reg <= `SEWPA_SDA_IDLE;
        end else begin
            sda_rise_reg <= sda_in;
            if (frame_new) begin
                start_seen_reg <= start_tog_reg;
                state_reg <= sewpa_ls_sel;
                cnt_reg <= 4'h1;
                shift_reg <= {7'h00, sda_in};
                commit_reg <= 1'b0;
            end else if (cnt_reg != `SEWPA_ACK_SLOT) begin
                shift_reg <= {shift_reg[6:0], sda_in};
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg != 4'h0) begin
                    commit_reg <= 1'b0;
                end
            end else begin
                cnt_reg <= 4'h0;
                case (state_reg)
                    sewpa_ls_sel: begin
                        kind_reg <= sewpa_kind_t'(dec[1:0]);
                        rw_reg <= shift_reg[`SEWPA_RW_BIT];
                        if (!ack_ok) begin
                            state_reg <= sewpa_ls_idle;
                        end else if (!shift_reg[`SEWPA_RW_BIT]) begin
                            state_reg <= sewpa_ls_addr;
                        end else if (dec[1:0] == sewpa_kind_mem) begin
                            tx_reg <= arr_q;
                            addr_reg <= addr_reg + 8'h01;
                            state_reg <= sewpa_ls_rdata;
                        end else begin
                            state_reg <= sewpa_ls_idle;
                        end
                    end
                    sewpa_ls_addr: begin
                        addr_reg <= shift_reg;
                        cmd_reg.kind <= kind_reg;
                        cmd_reg.page <= shift_reg[7:4];
                        cmd_reg.mask <= 16'h0000;
                        state_reg <= sewpa_ls_wdata;
                    end
                    sewpa_ls_wdata: begin
                        if (ack_ok) begin
                            commit_reg <= 1'b1;
                            cmd_reg.mask[addr_reg[3:0]] <= 1'b1;
                            addr_reg[3:0] <= addr_reg[3:0] + 4'h1;
                        end else begin
                            state_reg <= sewpa_ls_idle;
                        end
                    end
                    sewpa_ls_rdata: begin
                        if (sda_in) begin
                            state_reg <= sewpa_ls_idle;
                        end else begin
                            tx_reg <= arr_q;
                            addr_reg <= addr_reg + 8'h01;
                        end
                    end
                    default: state_reg <= sewpa_ls_idle;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Start detect and pin drive on falling clock
    // ------------------------------------------------------------------
    // The stop toggle has been still for the whole bus-free time when
    // this edge reads it, so no capture window exists.
    always_ff @(negedge scl_link_clk) begin
        if (rst_l2_reg) begin
            start_tog_reg <= 1'b0;
            stop_seen_reg <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if ((sda_rise_reg && !sda_in) || stop_tog_reg != stop_seen_reg) begin
            start_tog_reg <= ~start_tog_reg;
            stop_seen_reg <= stop_tog_reg;
            sda_oe_n <= 1'b1;
        end else if (state_reg == sewpa_ls_rdata) begin
            sda_oe_n <= cnt_reg == `SEWPA_ACK_SLOT || tx_reg[3'(4'h7 - cnt_reg)];
        end else begin
            sda_oe_n <= !(cnt_reg == `SEWPA_ACK_SLOT && ack_ok && !frame_new);
        end
    end

    assign sda_out = 1'b0;

    // ------------------------------------------------------------------
    // Core domain: stop detect and crossings
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {scl_c1_reg, scl_c2_reg, scl_c3_reg} <= 3'h7;
            {sda_c1_reg, sda_c2_reg, sda_c3_reg} <= 3'h7;
            commit_c1_reg <= 1'b0;
            commit_c2_reg <= 1'b0;
        end else begin
            scl_c1_reg <= scl_link_clk;
            scl_c2_reg <= scl_c1_reg;
            scl_c3_reg <= scl_c2_reg;
            sda_c1_reg <= sda_in;
            sda_c2_reg <= sda_c1_reg;
            sda_c3_reg <= sda_c2_reg;
            commit_c1_reg <= commit_reg;
            commit_c2_reg <= commit_c1_reg;
        end
    end

    assign stop_evt = scl_c2_reg && scl_c3_reg && sda_c2_reg && !sda_c3_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stop_tog_reg <= 1'b0;
        end else if (stop_evt) begin
            stop_tog_reg <= ~stop_tog_reg;
        end
    end

    // ------------------------------------------------------------------
    // Core domain: internal write cycle
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cstate_reg <= sewpa_cs_idle;
            ccmd_reg <= '0;
            lane_reg <= 5'h00;
            wait_reg <= 24'h000000;
        end else begin
            case (cstate_reg)
                sewpa_cs_idle: begin
                    lane_reg <= 5'h00;
                    wait_reg <= 24'h000000;
                    if (stop_evt && commit_c2_reg) begin
                        ccmd_reg <= cmd_reg;
                        cstate_reg <= sewpa_cs_walk;
                    end
                end
                sewpa_cs_walk: begin
                    lane_reg <= lane_reg + 5'h01;
                    if (lane_reg == `SEWPA_LANE_END) begin
                        cstate_reg <= sewpa_cs_wait;
                    end
                end
                sewpa_cs_wait: begin
                    wait_reg <= wait_reg + 24'h000001;
                    if (wait_reg == 24'(WRITE_CYCLES - 1)) begin
                        cstate_reg <= sewpa_cs_idle;
                    end
                end
                default: cstate_reg <= sewpa_cs_idle;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (cstate_reg == sewpa_cs_walk && lane_reg == 5'h00) begin
            if (ccmd_reg.kind == sewpa_kind_lock) begin
                lock_nv_reg <= 1'b1;
            end
            if (ccmd_reg.kind == sewpa_kind_set) begin
                set_nv_reg <= 1'b1;
            end
            if (ccmd_reg.kind == sewpa_kind_clr) begin
                set_nv_reg <= 1'b0;
            end
        end
    end

    assign arr_we = cstate_reg == sewpa_cs_walk && lane_reg != 5'h00 &&
                    ccmd_reg.kind == sewpa_kind_mem && ccmd_reg.mask[lane_reg[3:0] - 4'h1];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            write_busy <= 1'b0;
            protect_set <= 1'b0;
            protect_locked <= 1'b0;
        end else begin
            write_busy <= cstate_reg != sewpa_cs_idle;
            protect_set <= set_nv_reg;
            protect_locked <= lock_nv_reg;
        end
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Page latch: written by the link, drained by the core after stop
    sewpa_mem #(.AW(`SEWPA_LANE_W)) u_latch (
        .wr_clk(scl_link_clk),
        .wr_en(lat_we),
        .wr_addr(addr_reg[3:0]),
        .wr_data(shift_reg),
        .rd_clk(core_clk),
        .rd_addr(lane_reg[3:0]),
        .rd_data(lat_q)
    );

    // Array: link reads are refused while the core writes it
    sewpa_mem #(.AW(`SEWPA_ADDR_W)) u_array (
        .wr_clk(core_clk),
        .wr_en(arr_we),
        .wr_addr({ccmd_reg.page, lane_reg[3:0] - 4'h1}),
        .wr_data(lat_q),
        .rd_clk(scl_link_clk),
        .rd_addr(addr_reg),
        .rd_data(arr_q)
    );

endmodule : sewpa_wp_ack
`default_nettype wire

// file: sewpa_wp_ack_asserts.sv
// Port checker of the write-protect block.
// Assumes binding onto sewpa_wp_ack; all checks run on core_clk.
`timescale 1ns/1ps
`default_nettype none

module sewpa_wp_ack_asserts #(
    parameter int WRITE_CYCLES = 50
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic write_busy,
    input wire logic protect_set,
    input wire logic protect_locked
);
    // --------------------
    // Busy length counter
    // --------------------
    localparam int BUSY_LEN = 17 + WRITE_CYCLES;
    int busy_cnt;
    always_ff @(posedge core_clk) begin
        if (sys_rst || !write_busy) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // --------------------
    // Assertions
    // --------------------
    a_pin_low_only: assert property (
        sda_out == 1'b0) else $error("data pin drives high");
    a_busy_len: assert property (
        $fell(write_busy) |-> busy_cnt == BUSY_LEN) else $error("write cycle length wrong");
    a_busy_cap: assert property (
        write_busy |-> busy_cnt < BUSY_LEN) else $error("write cycle overruns");
    a_busy_quiet: assert property (
        write_busy |-> sda_oe_n) else $error("bus answered during write cycle");
    // Stored state shows up one edge after reset, hence the guards
    a_set_at_cycle: assert property (
        $rose(protect_set) && !$past(sys_rst) && !$past(sys_rst, 2) |-> ##[0:2] write_busy)
        else $error("set without write cycle");
    a_clear_at_cycle: assert property (
        $fell(protect_set) |-> ##[0:2] write_busy) else $error("clear without write cycle");
    a_lock_at_cycle: assert property (
        $rose(protect_locked) && !$past(sys_rst) && !$past(sys_rst, 2) |-> ##[0:2] write_busy)
        else $error("lock without write cycle");
    a_lock_kept: assert property (
        protect_locked |=> protect_locked) else $error("lock dropped");
endmodule : sewpa_wp_ack_asserts

bind sewpa_wp_ack sewpa_wp_ack_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_sewpa_wp_ack_asserts (
    .core_clk(core_clk), .sys_rst(sys_rst), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .write_busy(write_busy), .protect_set(protect_set), .protect_locked(protect_locked));
`default_nettype wire

// file: sewpa_bus_master.sv
// Two-wire bus master model: owns the bus clock and pulls data low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module sewpa_bus_master (
    output logic scl_link_clk,
    output logic sda_low,
    input wire logic sda_in
);
    // --------------------
    // Bus cycles, 100 ns clock per data bit, 80 ns idle pulses
    // --------------------
    initial begin
        scl_link_clk = 1'b1;
        sda_low = 1'b0;
    end
    // Idle pulses clock the whole link domain: reset and pin synchronisers and bit engine
    // Odd offset keeps bus edges apart from core clock edges
    task automatic pulse(input int n);
        #5;
        repeat (n) begin
            #40 scl_link_clk = 1'b0;
            #40 scl_link_clk = 1'b1;
        end
    endtask : pulse
    // Data moves mid low phase, sampled inside high phase
    task automatic bit_io(input logic b, output logic r);
        #40 scl_link_clk = 1'b0;
        #20 sda_low = ~b;
        #20 scl_link_clk = 1'b1;
        #20 r = sda_in;
    endtask : bit_io
    task automatic start_c(input logic rep);
        #5;
        if (rep) begin
            #40 scl_link_clk = 1'b0;
            #20 sda_low = 1'b0;
            #20 scl_link_clk = 1'b1;
        end
        #40 sda_low = 1'b1;
    endtask : start_c
    // Long high time so the core sees the stop
    task automatic stop_c();
        #40 scl_link_clk = 1'b0;
        #20 sda_low = 1'b1;
        #20 scl_link_clk = 1'b1;
        #80 sda_low = 1'b0;
        #80;
    endtask : stop_c
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put_byte
    // Stop after fewer than three bytes must not start a write
    task automatic xfer(input logic [7:0] sel, input logic [7:0] adr,
            input logic [7:0] dat, input int n, output logic [2:0] ak);
        ak = 3'h0;
        start_c(1'b0);
        put_byte(sel, ak[2]);
        put_byte(adr, ak[1]);
        if (n > 2) begin
            put_byte(dat, ak[0]);
        end
        stop_c();
    endtask : xfer
    // Random read of one byte, ended with NoAck
    task automatic rd_byte(input logic [7:0] sel, input logic [7:0] adr,
            output logic [7:0] d);
        logic a;
        start_c(1'b0);
        put_byte(sel, a);
        put_byte(adr, a);
        start_c(1'b1);
        put_byte(sel | 8'h01, a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b1, a);
        stop_c();
    endtask : rd_byte
endmodule : sewpa_bus_master
`default_nettype wire

// file: tb.sv
// Self-checking bench of the write-protect block.
// Assumes the checker binds itself; device sits in slot 5.
`timescale 1ns/1ps
`default_nettype none
`include "sewpa_cfg.svh"

module tb;
    localparam logic [2:0] SLOT = 3'h5;
    localparam logic [7:0] MEM_W = {`SEWPA_TYPE_MEM, SLOT, 1'b0};
    localparam logic [7:0] SET_W = {`SEWPA_TYPE_PROT, `SEWPA_CHIP_SET, 1'b0};
    localparam logic [7:0] CLR_W = {`SEWPA_TYPE_PROT, `SEWPA_CHIP_CLR, 1'b0};
    localparam logic [7:0] LCK_W = {`SEWPA_TYPE_PROT, SLOT, 1'b0};
    logic core_clk, sys_rst, scl, sda_low, sda_in, sda_out, sda_oe_n;
    logic guard, hv, busy, pset, plock;
    logic [2:0] straps;
    int err_total = 0;
    int n_tests = 0;
    // --------------------
    // Harness
    // --------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    assign sda_in = (sda_low || !sda_oe_n) ? 1'b0 : 1'b1;
    sewpa_wp_ack #(.WRITE_CYCLES(50)) u_sewpa_wp_ack (.core_clk(core_clk), .sys_rst(sys_rst),
        .scl_link_clk(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .array_write_guard(guard), .strap_select_bit0(straps[0]),
        .strap_select_bit1(straps[1]), .strap_select_bit2(straps[2]),
        .strap_high_voltage_level(hv), .write_busy(busy), .protect_set(pset),
        .protect_locked(plock));
    sewpa_bus_master u_sewpa_bus_master (.scl_link_clk(scl), .sda_low(sda_low),
        .sda_in(sda_in));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic pins(input logic g, input logic h);
        @(posedge core_clk);
        guard <= g;
        hv <= h;
    endtask : pins
    // Data byte is address xor 5a; window long enough for a full cycle
    task automatic wr(input logic [7:0] sel, input logic [7:0] adr, input int n,
            input logic [2:0] ea, input logic ew);
        logic [2:0] ak;
        logic seen;
        seen = 1'b0;
        u_sewpa_bus_master.xfer(sel, adr, adr ^ 8'h5a, n, ak);
        repeat (200) begin
            @(posedge core_clk);
            seen = seen | (busy === 1'b1);
        end
        check({5'h0, ak}, {5'h0, ea});
        check({7'h0, seen}, {7'h0, ew});
    endtask : wr
    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        logic [7:0] d;
        u_sewpa_bus_master.rd_byte(MEM_W, adr, d);
        check(d, exp);
    endtask : rd
    task automatic do_reset();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        u_sewpa_bus_master.pulse(4);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        u_sewpa_bus_master.pulse(4);
    endtask : do_reset
    // --------------------
    // Scenarios
    // --------------------
    task automatic t_blank();
        rd(8'h00, `SEWPA_ERASED);
        rd(8'hff, `SEWPA_ERASED);
        wr({`SEWPA_TYPE_MEM, 3'h4, 1'b0}, 8'h00, 3, 3'h0, 1'b0);
        $display("t_blank done");
    endtask : t_blank
    task automatic t_plain();
        wr(MEM_W, 8'h10, 3, 3'h7, 1'b1);
        rd(8'h10, 8'h4a);
        pins(1'b1, 1'b0);
        wr(MEM_W, 8'h90, 3, 3'h6, 1'b0);
        rd(8'h90, `SEWPA_ERASED);
        pins(1'b0, 1'b0);
        wr(MEM_W, 8'h11, 2, 3'h6, 1'b0);
        rd(8'h11, `SEWPA_ERASED);
        $display("t_plain done");
    endtask : t_plain
    task automatic t_set();
        pins(1'b1, 1'b1);
        wr(SET_W, 8'h00, 3, 3'h6, 1'b0);
        pins(1'b0, 1'b1);
        wr(SET_W, 8'h00, 3, 3'h7, 1'b1);
        check({7'h0, pset}, 8'h01);
        wr(MEM_W, 8'h20, 3, 3'h6, 1'b0);
        wr(MEM_W, 8'ha0, 3, 3'h7, 1'b1);
        rd(8'h20, `SEWPA_ERASED);
        rd(8'ha0, 8'hfa);
        wr(SET_W, 8'h00, 3, 3'h0, 1'b0);
        wr(CLR_W | 8'h01, 8'h00, 3, 3'h4, 1'b0);
        pins(1'b1, 1'b1);
        wr(CLR_W, 8'h00, 3, 3'h6, 1'b0);
        pins(1'b0, 1'b1);
        wr(CLR_W, 8'h00, 3, 3'h7, 1'b1);
        check({7'h0, pset}, 8'h00);
        wr(MEM_W, 8'h20, 3, 3'h7, 1'b1);
        $display("t_set done");
    endtask : t_set
    task automatic t_lock();
        logic [7:0] sels [3];
        sels = '{SET_W, CLR_W, LCK_W};
        wr(SET_W, 8'h00, 3, 3'h7, 1'b1);
        pins(1'b0, 1'b0);
        wr(LCK_W, 8'h00, 3, 3'h7, 1'b1);
        check({7'h0, plock}, 8'h01);
        pins(1'b0, 1'b1);
        foreach (sels[i]) begin
            wr(sels[i], 8'h00, 3, 3'h0, 1'b0);
        end
        wr(LCK_W | 8'h01, 8'h00, 3, 3'h0, 1'b0);
        wr(MEM_W, 8'h30, 3, 3'h6, 1'b0);
        do_reset();
        check({7'h0, plock}, 8'h01);
        $display("t_lock done");
    endtask : t_lock
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        sys_rst = 1'b1;
        guard = 1'b0;
        hv = 1'b0;
        straps = SLOT;
        do_reset();
        t_blank();
        t_plain();
        t_set();
        t_lock();
        finish_test();
    end
    // Run needs about 170 us; over seven times that means a hang
    initial begin
        #1250000;
        err_total++;
        finish_test();
    end
endmodule : tb
`default_nettype wire
